// >>> logic/dtp_consts.vh
`ifndef DTP_CONSTS_VH
`define DTP_CONSTS_VH

// register indices; byte address is 4 x index
`define DTP_IDX_TIMER_B_COUNT 5'h09
`define DTP_IDX_TIMER_B_CTL_ONE 5'h0a
`define DTP_IDX_TIMER_B_CTL_TWO 5'h0b
`define DTP_IDX_PRESCALER_B_COUNT 5'h0d
`define DTP_IDX_TONE_B_CONTROL 5'h0e
`define DTP_IDX_TIMER_C_COUNT 5'h10
`define DTP_IDX_TIMER_C_CTL_ONE 5'h11
`define DTP_IDX_TIMER_C_CTL_TWO 5'h12
`define DTP_IDX_PULSE_C_DUTY 5'h13
`define DTP_IDX_HIGH_BITS 5'h16

// control-one fields
`define DTP_BIT_RUN 0
`define DTP_BIT_RELOAD_SEL 1
`define DTP_BIT_SINGLE_SHOT 2
`define DTP_BIT_POLARITY 6
`define DTP_BIT_OUT_EN 7
// control-two fields
`define DTP_BIT_PRESC_EN_N 3
`define DTP_BIT_EDGE_SEL 4
`define DTP_BIT_SOURCE_SEL 5
// tone control fields
`define DTP_BIT_TONE_EN 7
`define DTP_BIT_TONE_SRC 3
// shared high-bits register fields
`define DTP_HB_TIMER_B_HI 7:6
`define DTP_HB_TIMER_C_HI 5:4
`define DTP_HB_DUTY_C_HI 1:0

// read masks, reset values and the wrap value
`define DTP_CTL_ONE_MASK 8'hc7
`define DTP_CTL_TWO_MASK 8'h3f
`define DTP_CTL_ONE_RESET 8'h00
`define DTP_CTL_TWO_RESET 8'h3f
`define DTP_TONE_RESET 8'h0f
`define DTP_PRESC_RESET 8'hff
`define DTP_WRAP_VALUE 10'h3ff

// axi responses
`define DTP_RESP_OKAY 2'b00
`define DTP_RESP_SLVERR 2'b10

`endif

// >>> logic/dtp_sync3.v
// three-stage synchroniser; the output level changes only once
// the second and third stages agree, which filters a one-stage glitch
module dtp_sync3 (
    input wire aclk,
    input wire aresetn,
    input wire pin_in,
    output reg level_reg
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // first stage feeds only the second stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
            end
        end
    end
endmodule // dtp_sync3

// >>> logic/dtp_timer.v
`include "dtp_consts.vh"

// 10-bit down-counter with an 8-bit prescaler in front of it
module dtp_timer (
    input wire aclk,
    input wire aresetn,
    input wire run,
    input wire single_shot,
    input wire reload_select,
    input wire source_ext,
    input wire edge_fall,
    input wire presc_en_n,
    input wire [2:0] rate,
    input wire ext_rise,
    input wire ext_fall,
    input wire load,
    input wire [9:0] load_value,
    output reg [9:0] count_reg,
    output reg [9:0] reload_reg,
    output reg [7:0] presc_reg
);
    wire event_w;
    wire [8:0] span;
    wire [7:0] mask;
    wire presc_wrap;
    wire tick;

    // clock event: instruction clock is every aclk, else the chosen pin edge
    assign event_w = source_ext ? (edge_fall ? ext_fall : ext_rise) : 1'b1;
    // division by 2^(rate+1): low rate+1 bits of the prescaler all zero
    assign span = (9'h002 << rate) - 9'h001;
    assign mask = span[7:0];
    assign presc_wrap = (presc_reg & mask) == 8'h00;
    // prescaler bypassed gives one decrement per event
    assign tick = run & event_w & (presc_en_n | presc_wrap);

    // prescaler only moves while enabled and the timer runs
    always @(posedge aclk) begin
        if (!aresetn) begin
            presc_reg <= `DTP_PRESC_RESET;
        end else if (run && event_w && !presc_en_n) begin
            presc_reg <= presc_reg - 8'h01;
        end
    end

    // a count write loads reload and live count; load beats a tick
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= 10'h000;
            reload_reg <= 10'h000;
        end else if (load) begin
            count_reg <= load_value;
            reload_reg <= load_value;
        end else if (tick) begin
            if (count_reg == 10'h000) begin
                if (!single_shot) begin
                    // non-stop: wrap to full scale or to the reload value
                    count_reg <= reload_select ? reload_reg : `DTP_WRAP_VALUE;
                end
                // single shot: hold at zero, reload select ignored
            end else begin
                count_reg <= count_reg - 10'h001;
            end
        end
    end
endmodule // dtp_timer

// >>> logic/dtp_top.v
//
// Notes on behaviour
// - prescaler_b_count reads the live prescaler B counter; read-only.
// - tone codes 0000-0111 take prescaler B divided by 2 to 256.
// - tone codes 1000-1111 use timer B count bit 0 to bit 7.
// - tone enable set drives the tone output, else it is off.
// - timer_c_count reads the low byte of the 10-bit counter.
// - timer_c_count write loads high bits and byte to reload and count.
// - timer C counts only while its run bit is one.
// - non-stop, reload select 0: underflow loads 0x3ff, counting on.
// - non-stop, reload select 1: underflow loads the reload value.
// - single shot counts to zero once, then stops; reload select ignored.
// - pulse polarity set makes the pulse active low, else high.
// - pulse output enable drives the pulse pin, else the pin is GPIO.
// - prescaler C rate codes 000-111 divide by 2 to 256.
// - active-low prescaler enable inserts prescaler C when zero.
// - edge select 1 counts falling pin edges, 0 rising ones.
// - source select 1 clocks from the pin, 0 from the instruction clock.
// - reload value sets pulse frame; 10-bit duty sets active width.
// - timer B feeding the tone selector is a 10-bit down-counter.
//
// Added by the designer: register access over AXI4-Lite.
`include "dtp_consts.vh"

module dtp_top (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire external_count_clock_pin,
    output reg pulse_c_pin_out,
    output reg pulse_c_pin_oe,
    output reg tone_b_pin_out,
    output reg tone_b_pin_oe
);

    ////////////////////////////////////////////////////////////////////////
    // register storage

    reg [7:0] timer_b_control_one_reg;
    reg [7:0] timer_b_control_two_reg;
    reg [7:0] tone_b_control_reg;
    reg [7:0] timer_c_control_one_reg;
    reg [7:0] timer_c_control_two_reg;
    reg [7:0] pulse_c_duty_reg;
    reg [7:0] timer_c_high_bits_reg;

    // write path holding state
    reg aw_held_reg;
    reg w_held_reg;
    reg [4:0] aw_index_reg;
    reg [7:0] w_byte_reg;
    reg w_lane_reg;

    // external pin edges
    reg ext_prev_reg;
    wire ext_level;
    wire ext_rise;
    wire ext_fall;

    // timer outputs
    wire [9:0] timer_b_count;
    wire [9:0] timer_b_reload;
    wire [7:0] prescaler_b_count;
    wire [9:0] timer_c_count;
    wire [9:0] timer_c_reload;
    wire [7:0] prescaler_c_count;

    wire write_fire;
    wire load_b;
    wire load_c;
    wire [9:0] pulse_c_duty_full;
    wire [3:0] tone_b_freq_select;
    wire tone_b_enable;
    wire pulse_c_active;
    wire tone_b_wave;

    reg [7:0] read_byte;
    reg read_hit;
    reg write_hit;

    ////////////////////////////////////////////////////////////////////////
    // external count clock pin: synchronise, then find edges

    dtp_sync3 u_ext_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(external_count_clock_pin),
        .level_reg(ext_level)
    );

    // edges come from the filtered level, never from raw stages
    always @(posedge aclk) begin
        if (!aresetn) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_level;
        end
    end

    assign ext_rise = ext_level & ~ext_prev_reg;
    assign ext_fall = ~ext_level & ext_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel

    // a write commits once address and data are both held and no
    // response is pending; one write at a time keeps the slave simple
    assign write_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign load_b = write_fire & w_lane_reg & (aw_index_reg == `DTP_IDX_TIMER_B_COUNT);
    assign load_c = write_fire & w_lane_reg & (aw_index_reg == `DTP_IDX_TIMER_C_COUNT);

    // address and data are taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_index_reg <= 5'h00;
            w_byte_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_index_reg <= s_axi_awaddr[6:2];
                s_axi_awready <= 1'b0;
            end else if (write_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_byte_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (write_fire) begin
                w_held_reg <= 1'b0;
            end
            // ready returns once the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // decode of writable indices
    always @* begin
        case (aw_index_reg)
            `DTP_IDX_TIMER_B_COUNT,
            `DTP_IDX_TIMER_B_CTL_ONE,
            `DTP_IDX_TIMER_B_CTL_TWO,
            `DTP_IDX_TONE_B_CONTROL,
            `DTP_IDX_TIMER_C_COUNT,
            `DTP_IDX_TIMER_C_CTL_ONE,
            `DTP_IDX_TIMER_C_CTL_TWO,
            `DTP_IDX_PULSE_C_DUTY,
            `DTP_IDX_HIGH_BITS: write_hit = 1'b1;
            default: write_hit = 1'b0;
        endcase
    end

    // write response; the read-only prescaler count answers an error
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DTP_RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= write_hit ? `DTP_RESP_OKAY : `DTP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register updates; only byte lane 0 carries data
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_b_control_one_reg <= `DTP_CTL_ONE_RESET;
            timer_b_control_two_reg <= `DTP_CTL_TWO_RESET;
            tone_b_control_reg <= `DTP_TONE_RESET;
            timer_c_control_one_reg <= `DTP_CTL_ONE_RESET;
            timer_c_control_two_reg <= `DTP_CTL_TWO_RESET;
            pulse_c_duty_reg <= 8'h00;
            timer_c_high_bits_reg <= 8'h00;
        end else if (write_fire && w_lane_reg) begin
            case (aw_index_reg)
                `DTP_IDX_TIMER_B_CTL_ONE: begin
                    timer_b_control_one_reg <= w_byte_reg & `DTP_CTL_ONE_MASK;
                end
                `DTP_IDX_TIMER_B_CTL_TWO: begin
                    timer_b_control_two_reg <= w_byte_reg & `DTP_CTL_TWO_MASK;
                end
                `DTP_IDX_TONE_B_CONTROL: begin
                    tone_b_control_reg <= w_byte_reg;
                end
                `DTP_IDX_TIMER_C_CTL_ONE: begin
                    timer_c_control_one_reg <= w_byte_reg & `DTP_CTL_ONE_MASK;
                end
                `DTP_IDX_TIMER_C_CTL_TWO: begin
                    // rate changes while enabled are software's hazard
                    timer_c_control_two_reg <= w_byte_reg & `DTP_CTL_TWO_MASK;
                end
                `DTP_IDX_PULSE_C_DUTY: begin
                    pulse_c_duty_reg <= w_byte_reg;
                end
                `DTP_IDX_HIGH_BITS: begin
                    timer_c_high_bits_reg <= w_byte_reg;
                end
                default: begin
                    pulse_c_duty_reg <= pulse_c_duty_reg;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel

    // read mux; write-only registers read as zero
    always @* begin
        read_byte = 8'h00;
        read_hit = 1'b1;
        case (s_axi_araddr[6:2])
            `DTP_IDX_TIMER_B_COUNT: read_byte = timer_b_count[7:0];
            `DTP_IDX_TIMER_B_CTL_ONE: read_byte = timer_b_control_one_reg;
            `DTP_IDX_TIMER_B_CTL_TWO: read_byte = timer_b_control_two_reg;
            `DTP_IDX_PRESCALER_B_COUNT: read_byte = prescaler_b_count;
            `DTP_IDX_TONE_B_CONTROL: read_byte = 8'h00;
            `DTP_IDX_TIMER_C_COUNT: read_byte = timer_c_count[7:0];
            `DTP_IDX_TIMER_C_CTL_ONE: read_byte = timer_c_control_one_reg;
            `DTP_IDX_TIMER_C_CTL_TWO: read_byte = timer_c_control_two_reg;
            `DTP_IDX_PULSE_C_DUTY: read_byte = 8'h00;
            `DTP_IDX_HIGH_BITS: read_byte = timer_c_high_bits_reg;
            default: read_hit = 1'b0;
        endcase
    end

    // one read in flight; arready drops while data waits
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DTP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, read_byte};
            s_axi_rresp <= read_hit ? `DTP_RESP_OKAY : `DTP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timers

    // timer B: 10-bit down-counter feeding the tone selector
    dtp_timer u_timer_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(timer_b_control_one_reg[`DTP_BIT_RUN]),
        .single_shot(timer_b_control_one_reg[`DTP_BIT_SINGLE_SHOT]),
        .reload_select(timer_b_control_one_reg[`DTP_BIT_RELOAD_SEL]),
        .source_ext(timer_b_control_two_reg[`DTP_BIT_SOURCE_SEL]),
        .edge_fall(timer_b_control_two_reg[`DTP_BIT_EDGE_SEL]),
        .presc_en_n(timer_b_control_two_reg[`DTP_BIT_PRESC_EN_N]),
        .rate(timer_b_control_two_reg[2:0]),
        .ext_rise(ext_rise),
        .ext_fall(ext_fall),
        .load(load_b),
        .load_value({timer_c_high_bits_reg[`DTP_HB_TIMER_B_HI], w_byte_reg}),
        .count_reg(timer_b_count),
        .reload_reg(timer_b_reload),
        .presc_reg(prescaler_b_count)
    );

    // timer C: drives the pulse output
    dtp_timer u_timer_c (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(timer_c_control_one_reg[`DTP_BIT_RUN]),
        .single_shot(timer_c_control_one_reg[`DTP_BIT_SINGLE_SHOT]),
        .reload_select(timer_c_control_one_reg[`DTP_BIT_RELOAD_SEL]),
        .source_ext(timer_c_control_two_reg[`DTP_BIT_SOURCE_SEL]),
        .edge_fall(timer_c_control_two_reg[`DTP_BIT_EDGE_SEL]),
        .presc_en_n(timer_c_control_two_reg[`DTP_BIT_PRESC_EN_N]),
        .rate(timer_c_control_two_reg[2:0]),
        .ext_rise(ext_rise),
        .ext_fall(ext_fall),
        .load(load_c),
        .load_value({timer_c_high_bits_reg[`DTP_HB_TIMER_C_HI], w_byte_reg}),
        .count_reg(timer_c_count),
        .reload_reg(timer_c_reload),
        .presc_reg(prescaler_c_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // pulse output

    // the frame is the reload period of the down-count; the output is
    // active while the count sits below the 10-bit duty value
    assign pulse_c_duty_full = {timer_c_high_bits_reg[`DTP_HB_DUTY_C_HI], pulse_c_duty_reg};
    assign pulse_c_active = (timer_c_count < pulse_c_duty_full);

    // pin stays GPIO (not driven) while the output enable is clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            pulse_c_pin_out <= 1'b0;
            pulse_c_pin_oe <= 1'b0;
        end else begin
            pulse_c_pin_out <= pulse_c_active ^
                timer_c_control_one_reg[`DTP_BIT_POLARITY];
            pulse_c_pin_oe <= timer_c_control_one_reg[`DTP_BIT_OUT_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tone output

    assign tone_b_freq_select = tone_b_control_reg[3:0];
    assign tone_b_enable = tone_b_control_reg[`DTP_BIT_TONE_EN];
    // prescaler bit n toggles every 2^n events, i.e. a square wave at
    // 1/2^(n+1); a frozen prescaler or timer leaves the tone static
    assign tone_b_wave = tone_b_freq_select[`DTP_BIT_TONE_SRC] ?
        timer_b_count[tone_b_freq_select[2:0]] :
        prescaler_b_count[tone_b_freq_select[2:0]];

    // disabled tone parks low and releases the pin
    always @(posedge aclk) begin
        if (!aresetn) begin
            tone_b_pin_out <= 1'b0;
            tone_b_pin_oe <= 1'b0;
        end else begin
            tone_b_pin_out <= tone_b_enable & tone_b_wave;
            tone_b_pin_oe <= tone_b_enable;
        end
    end

endmodule // dtp_top

// >>> testbench/dtp_top_properties.sv
// bus handshake and pin checks for dtp_top
module dtp_top_properties (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire pulse_c_pin_oe,
    input wire tone_b_pin_out,
    input wire tone_b_pin_oe
);
    // one clock domain
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////
    // read: answer the edge after the address, held until taken
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not closed");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("rdata upper bits set");

    ////////////////////////////////////////////////
    // write: commit edge first, response the edge after
    a_write_latency: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer late");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    a_write_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write taken early");

    ////////////////////////////////////////////////
    // pins: disabled tone stays low; pulse enable moves only after a write
    a_tone_quiet: assert property (!tone_b_pin_oe [*2] |-> !tone_b_pin_out)
        else $error("tone active while off");
    a_pin_oe_cause: assert property ($changed(pulse_c_pin_oe)
        |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("pulse enable moved alone");
endmodule // dtp_top_properties

bind dtp_top dtp_top_properties dtp_top_properties_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pulse_c_pin_oe(pulse_c_pin_oe),
    .tone_b_pin_out(tone_b_pin_out), .tone_b_pin_oe(tone_b_pin_oe)
);

// >>> testbench/test_down_timer_prescaler_buzzer.sv
module test_down_timer_prescaler_buzzer;
    timeunit 1ns;
    timeprecision 1ps;
    // byte addresses
    localparam logic [7:0] r_bcnt = 8'h24, r_b1 = 8'h28, r_b2 = 8'h2c, r_psb = 8'h34;
    localparam logic [7:0] r_tone = 8'h38, r_cnt = 8'h40, r_c1 = 8'h44, r_c2 = 8'h48;
    localparam logic [7:0] r_dty = 8'h4c, r_hb = 8'h58, r_bad = 8'h7c;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, external_count_clock_pin = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire pulse_c_pin_out, pulse_c_pin_oe, tone_b_pin_out, tone_b_pin_oe;
    logic [1:0] rsp;
    logic [31:0] q;
    int n_errors = 0;
    int compares = 0;

    dtp_top dtp_top_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .external_count_clock_pin(external_count_clock_pin),
        .pulse_c_pin_out(pulse_c_pin_out), .pulse_c_pin_oe(pulse_c_pin_oe),
        .tone_b_pin_out(tone_b_pin_out), .tone_b_pin_oe(tone_b_pin_oe)
    );

    // 40 MHz clock
    initial begin
        forever #12.5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////
    task automatic end_sim;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // a bus wait that runs out fails the run
    task automatic tmo;
        n_errors++;
        $display("CHECK FAILED bus wait expected answer seen none");
        end_sim();
    endtask

    // address and data together; bready once bvalid is seen
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 60);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
        if (n >= 60) tmo();
    endtask

    // rready comes late so the slave must hold its answer
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 60);
        s_axi_rready <= 1'b0;
        q = s_axi_rdata;
        rsp = s_axi_rresp;
        if (n >= 60) tmo();
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
        rd(a);
        chk(nm, q, {24'h0, e});
    endtask

    // write, then let the pins settle
    task automatic wrs(input logic [7:0] a, input logic [7:0] d);
        wr(a, d);
        repeat (3) @(posedge aclk);
    endtask

    // each level held long enough to pass the synchroniser
    task automatic pin(input logic v);
        @(posedge aclk);
        external_count_clock_pin <= v;
        repeat (8) @(posedge aclk);
    endtask

    task automatic edges(input int k);
        repeat (k) begin
            pin(1'b1);
            pin(1'b0);
        end
    endtask

    ////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, write-only and unmapped
        rc(r_c1, 8'h00, "ctl_one reset");
        rc(r_c2, 8'h3f, "ctl_two reset");
        rc(r_psb, 8'hff, "prescaler_b reset");
        rc(r_tone, 8'h00, "tone read");
        rc(r_bad, 8'h00, "unmapped read");
        chk("unmapped rresp", rsp, 2'b10);
        wr(r_bad, 8'h12);
        chk("unmapped bresp", rsp, 2'b10);
        $display("test registers done");
        // five pin events into prescaler b, then a refused write
        wr(r_b2, 8'h27);
        wr(r_b1, 8'h01);
        edges(5);
        wr(r_b1, 8'h00);
        wr(r_psb, 8'h00);
        chk("read-only bresp", rsp, 2'b10);
        rc(r_psb, 8'hfa, "prescaler_b live");
        for (int c = 0; c < 16; c++) begin
            if (c == 8) begin
                wr(r_hb, 8'h00);
                wr(r_bcnt, 8'h55);
            end
            wrs(r_tone, 8'h80 | c[7:0]);
            chk("tone enable", tone_b_pin_oe, 1);
            if (c < 8) chk("tone prescaler", tone_b_pin_out, (8'hfa >> c) & 1);
            else chk("tone timer bit", tone_b_pin_out, (8'h55 >> (c - 8)) & 1);
        end
        wrs(r_tone, 8'h0f);
        chk("tone off", {tone_b_pin_oe, tone_b_pin_out}, 0);
        $display("test tone done");
        // timer c on rising pin edges, prescaler bypassed
        wr(r_c2, 8'h28);
        wr(r_hb, 8'h10);
        wr(r_cnt, 8'h02);
        edges(2);
        rc(r_cnt, 8'h02, "halted count");
        wr(r_c1, 8'h03);
        edges(3);
        rc(r_cnt, 8'hff, "high bits loaded");
        wr(r_hb, 8'h00);
        wr(r_cnt, 8'h02);
        edges(3);
        rc(r_cnt, 8'h02, "reload value");
        wr(r_c1, 8'h01);
        edges(3);
        rc(r_cnt, 8'hff, "wrap to 3ff");
        wr(r_cnt, 8'h02);
        wr(r_c1, 8'h07);
        edges(4);
        rc(r_cnt, 8'h00, "single shot");
        $display("test modes done");
        // falling edge select, then the instruction clock
        wr(r_c2, 8'h38);
        wr(r_c1, 8'h01);
        wr(r_cnt, 8'h10);
        pin(1'b1);
        rc(r_cnt, 8'h10, "rise ignored");
        pin(1'b0);
        rc(r_cnt, 8'h0f, "fall counted");
        wr(r_c1, 8'h05);
        wr(r_c2, 8'h08);
        repeat (30) @(posedge aclk);
        rc(r_cnt, 8'h00, "instr clock");
        // every rate, changed only with the prescaler off
        wr(r_c1, 8'h01);
        for (int r = 0; r < 8; r++) begin
            wr(r_c2, 8'h28 | r[7:0]);
            wr(r_cnt, 8'h10);
            wr(r_c2, 8'h20 | r[7:0]);
            edges(4 << r);
            rc(r_cnt, 8'h0e, "prescaled count");
        end
        $display("test prescaler done");
        // pulse output against a halted count of 0x0e
        wr(r_dty, 8'h80);
        wrs(r_c1, 8'h80);
        chk("pulse high", {pulse_c_pin_oe, pulse_c_pin_out}, 2'b11);
        wrs(r_c1, 8'hc0);
        chk("pulse low", pulse_c_pin_out, 0);
        wrs(r_dty, 8'h0e);
        chk("duty equal", pulse_c_pin_out, 1);
        wrs(r_dty, 8'h0f);
        chk("duty above", pulse_c_pin_out, 0);
        wrs(r_c1, 8'h00);
        chk("pin released", pulse_c_pin_oe, 0);
        $display("test pulse done");
        end_sim();
    end
endmodule // test_down_timer_prescaler_buzzer
